// file: logic/throw_switch_pkg.sv
/*
 holds register map, field positions, reset values and timing counts
 for the four-throw switch control block.
 assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none
package throw_switch_pkg;
    localparam int           ADDR_W            = 8;
    localparam int           DATA_W            = 8;
    localparam int           NUM_THROWS        = 4;
    localparam logic [7:0]   SWITCH_CTRL_ADDR  = 8'h20;
    localparam logic [7:0]   SWITCH_CTRL_RESET = 8'h00;
    localparam logic [7:0]   IRQ_STATUS_ADDR   = 8'h21;
    localparam logic [7:0]   IRQ_MASK_ADDR     = 8'h22;
    localparam logic [7:0]   MODE_CTRL_ADDR    = 8'h23;
    localparam logic [7:0]   IRQ_MASK_RESET    = 8'h00;
    localparam logic [7:0]   MODE_CTRL_RESET   = 8'h00;
    localparam int           FAULT_MSB         = 7;
    localparam int           FAULT_LSB         = 6;
    localparam int           RSVD_MSB          = 5;
    localparam int           RSVD_LSB          = 4;
    localparam int           THROW_MSB         = 3;
    localparam int           THROW_LSB         = 0;
    localparam logic [1:0]   FAULT_NONE        = 2'h0;
    localparam int           IRQ_FAULT_BIT     = 0;
    localparam int           IRQ_CHANGE_BIT    = 1;
    localparam int           MODE_PAR_BIT      = 0;
    localparam int           CLK_MHZ           = 250;
    localparam int           CHECK_TIME_NS     = 1000;
    localparam int           CHECK_CYCLES      = (CHECK_TIME_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [2:0] {
        ST_CHECK = 3'h1,
        ST_LATCH = 3'h2,
        ST_RUN   = 3'h4
    } boot_state_e;
endpackage : throw_switch_pkg
`default_nettype wire

// file: logic/sync2.sv
/*
 holds a two flip-flop synchroniser for one level.
 assumes the destination clock and its active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output var  logic q
);
    logic meta_q;
    logic meta_d;
    logic q_d;
    always_comb begin
        meta_d = d;
        q_d    = meta_q;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RESET_VAL;
            q      <= RESET_VAL;
        end else begin
            meta_q <= meta_d;
            q      <= q_d;
        end
    end
endmodule : sync2
`default_nettype wire

// file: logic/sticky_flag.sv
/*
 holds one sticky event bit: a set in the clearing cycle wins.
 assumes set and clear are single-cycle pulses on clk.
*/
`timescale 1ns/1ns
`default_nettype none
module sticky_flag (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic set,
    input  wire logic clr,
    output var  logic flag
);
    logic flag_d;
    always_comb begin
        flag_d = flag;
        if (clr) begin
            flag_d = 1'b0;
        end
        if (set) begin
            flag_d = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else begin
            flag <= flag_d;
        end
    end
endmodule : sticky_flag
`default_nettype wire

// file: logic/throw_switch_ctrl.sv
/*
 holds the control/status register of a four-throw switch, its
 power-up configuration check, parallel pin path and interrupt.
 assumes a simple strobe register port on clk; the parallel pins and
 the configuration-error pins are asynchronous and are synchronised.
*/
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - four 8-bit registers at 0x20-0x23; control at 0x20, reset 0x00
// - bits 7:6 read-only fault, nonzero means fault
// - bits 5:4 reserved, read zero, write zero
// - bit 3 closes fourth throw
// - bit 2 closes third throw
// - bit 1 closes second throw
// - bit 0 closes first throw
// - power-up configuration error sets fault field
// - four parallel pins can drive the throws
module throw_switch_ctrl
    import throw_switch_pkg::*;
#(
    parameter int CHECK_COUNT = CHECK_CYCLES
) (
    input  wire logic                           clk,
    input  wire logic                           resetn,
    input  wire logic [throw_switch_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [throw_switch_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output var  logic [throw_switch_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic [1:0]                     config_error,
    input  wire logic [throw_switch_pkg::NUM_THROWS-1:0] parallel_throw_input,
    output var  logic [throw_switch_pkg::NUM_THROWS-1:0] throw_close,
    output var  logic                           irq
);
    import throw_switch_pkg::*;

    logic                  rst_meta_q;
    logic                  rst_meta_d;
    logic                  rst_n;
    logic                  rst_n_d;

    // assert at once, release through two stages so that every flop
    // leaves reset on the same clk edge
    always_comb begin
        rst_meta_d = 1'b1;
        rst_n_d    = rst_meta_q;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= rst_meta_d;
            rst_n      <= rst_n_d;
        end
    end

    logic [NUM_THROWS-1:0] par_sync;
    logic [1:0]            cfg_sync;

    // a pin change reaches the throw outputs three edges later
    genvar gi;
    generate
        for (gi = 0; gi < NUM_THROWS; gi++) begin : g_par
            sync2 #(.RESET_VAL(1'b0)) u_par_sync (
                .clk   (clk),
                .rst_n (rst_n),
                .d     (parallel_throw_input[gi]),
                .q     (par_sync[gi])
            );
        end
        for (gi = 0; gi < 2; gi++) begin : g_cfg
            sync2 #(.RESET_VAL(1'b0)) u_cfg_sync (
                .clk   (clk),
                .rst_n (rst_n),
                .d     (config_error[gi]),
                .q     (cfg_sync[gi])
            );
        end
    endgenerate

    // power-up check: after the configuration settles, latch its error
    // code once; a later change of the pins is not a power-up event
    boot_state_e           boot_q;
    boot_state_e           boot_d;
    logic [15:0]           chk_cnt_q;
    logic [15:0]           chk_cnt_d;
    logic [1:0]            fault_q;
    logic [1:0]            fault_d;
    logic                  fault_evt;

    always_comb begin
        boot_d    = boot_q;
        chk_cnt_d = chk_cnt_q;
        case (boot_q)
            ST_CHECK: begin
                if (chk_cnt_q >= 16'(CHECK_COUNT - 1)) begin
                    boot_d = ST_LATCH;
                end else begin
                    chk_cnt_d = chk_cnt_q + 16'h0001;
                end
            end
            ST_LATCH: begin
                boot_d = ST_RUN;
            end
            ST_RUN: begin
                boot_d = ST_RUN;
            end
            default: begin
                boot_d = ST_CHECK;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_q    <= ST_CHECK;
            chk_cnt_q <= 16'h0000;
        end else begin
            boot_q    <= boot_d;
            chk_cnt_q <= chk_cnt_d;
        end
    end

    // limitation: the fault field reads zero while the check still counts
    always_comb begin
        fault_d   = fault_q;
        fault_evt = 1'b0;
        if (boot_q == ST_LATCH) begin
            fault_d   = cfg_sync;
            fault_evt = (cfg_sync != FAULT_NONE);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_q <= FAULT_NONE;
        end else begin
            fault_q <= fault_d;
        end
    end

    // registers
    logic [NUM_THROWS-1:0] throw_reg_q;
    logic [NUM_THROWS-1:0] throw_reg_d;
    logic [7:0]            mask_q;
    logic [7:0]            mask_d;
    logic                  par_mode_q;
    logic                  par_mode_d;
    logic [DATA_W-1:0]     rdata_d;
    logic [NUM_THROWS-1:0] throw_close_d;
    logic                  irq_d;
    logic                  wr_ctrl;
    logic                  wr_mask;
    logic                  wr_mode;
    logic                  status_rd;
    logic [7:0]            status_w;
    logic                  change_evt;
    logic                  st_fault;
    logic                  st_change;

    // the strobes never come together, so each decode stands alone
    assign wr_ctrl   = reg_wr && (reg_addr == SWITCH_CTRL_ADDR);
    assign wr_mask   = reg_wr && (reg_addr == IRQ_MASK_ADDR);
    assign wr_mode   = reg_wr && (reg_addr == MODE_CTRL_ADDR);
    assign status_rd = reg_rd && (reg_addr == IRQ_STATUS_ADDR);
    assign status_w  = {6'h00, st_change, st_fault};

    always_comb begin
        throw_reg_d = throw_reg_q;
        if (wr_ctrl) begin
            // only the throw bits store; fault and reserved lanes drop
            throw_reg_d = reg_wdata[THROW_MSB:THROW_LSB];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            throw_reg_q <= SWITCH_CTRL_RESET[THROW_MSB:THROW_LSB];
        end else begin
            throw_reg_q <= throw_reg_d;
        end
    end

    // mask keeps the two defined event bits; the rest read zero
    always_comb begin
        mask_d = mask_q;
        if (wr_mask) begin
            mask_d = {6'h00, reg_wdata[1:0]};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= IRQ_MASK_RESET;
        end else begin
            mask_q <= mask_d;
        end
    end

    always_comb begin
        par_mode_d = par_mode_q;
        if (wr_mode) begin
            par_mode_d = reg_wdata[MODE_PAR_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            par_mode_q <= MODE_CTRL_RESET[MODE_PAR_BIT];
        end else begin
            par_mode_q <= par_mode_d;
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                // stored bits, not the pins: software sees what it wrote
                SWITCH_CTRL_ADDR: begin
                    rdata_d[FAULT_MSB:FAULT_LSB] = fault_q;
                    rdata_d[RSVD_MSB:RSVD_LSB]   = 2'h0;
                    rdata_d[THROW_MSB:THROW_LSB] = throw_reg_q;
                end
                IRQ_STATUS_ADDR: begin
                    rdata_d = status_w;
                end
                IRQ_MASK_ADDR: begin
                    rdata_d = mask_q;
                end
                MODE_CTRL_ADDR: begin
                    rdata_d = {7'h00, par_mode_q};
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    // pins take over when parallel mode is selected; the register keeps
    // its bits meanwhile and drives again once the mode is left
    always_comb begin
        if (par_mode_q) begin
            throw_close_d = par_sync;
        end else begin
            throw_close_d[3] = throw_reg_q[3];
            throw_close_d[2] = throw_reg_q[2];
            throw_close_d[1] = throw_reg_q[1];
            throw_close_d[0] = throw_reg_q[0];
        end
    end

    // any move of the outputs is an event, whichever source caused it
    always_comb begin
        change_evt = (throw_close_d != throw_close);
        irq_d      = (st_fault && mask_q[IRQ_FAULT_BIT])
                  || (st_change && mask_q[IRQ_CHANGE_BIT]);
    end

    // an event in the reading cycle stays set for the next read
    sticky_flag u_st_fault (
        .clk   (clk),
        .rst_n (rst_n),
        .set   (fault_evt),
        .clr   (status_rd),
        .flag  (st_fault)
    );

    sticky_flag u_st_change (
        .clk   (clk),
        .rst_n (rst_n),
        .set   (change_evt),
        .clr   (status_rd),
        .flag  (st_change)
    );

    // read data are zero outside the answer cycle, so a stale value
    // can never be taken for a fresh one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    // outputs straight from flops: no decode glitch reaches the drivers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            throw_close <= 4'h0;
            irq         <= 1'b0;
        end else begin
            throw_close <= throw_close_d;
            irq         <= irq_d;
        end
    end
endmodule : throw_switch_ctrl
`default_nettype wire

// file: bench/throw_switch_ctrl_properties.sv
/*
 concurrent checks on the switch register block's ports.
 assumes a bind from the bench; mask and mode are tracked from bus writes.
*/
`timescale 1ns/1ns
`default_nettype none
module throw_switch_ctrl_properties
    import throw_switch_pkg::*;
#(
    parameter int CHECK_COUNT = 4
) (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] parallel_throw_input,
    input wire logic [3:0] throw_close,
    input wire logic       irq
);
    logic       mode_q;
    logic [1:0] mask_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // shadow copies so throw and irq checks know which source rules
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= 1'b0;
            mask_q <= 2'h0;
        end else if (reg_wr) begin
            if (reg_addr == MODE_CTRL_ADDR) mode_q <= reg_wdata[MODE_PAR_BIT];
            if (reg_addr == IRQ_MASK_ADDR) mask_q <= reg_wdata[1:0];
        end
    end
    chk_reset_outputs_quiet: assert property (disable iff (1'b0)
        !resetn |-> throw_close == 4'h0 && !irq && reg_rdata == 8'h00)
        else $error("outputs not quiet in reset");
    chk_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    chk_reserved_read_zero: assert property ($past(reg_rd) &&
        $past(reg_addr) == SWITCH_CTRL_ADDR |-> reg_rdata[5:4] == 2'h0)
        else $error("reserved bits read nonzero");
    chk_unmapped_read_zero: assert property ($past(reg_rd) &&
        ($past(reg_addr) < SWITCH_CTRL_ADDR || $past(reg_addr) > MODE_CTRL_ADDR)
        |-> reg_rdata == 8'h00)
        else $error("unmapped read nonzero");
    chk_throw_readback: assert property (reg_wr && reg_addr == SWITCH_CTRL_ADDR ##1
        reg_rd && reg_addr == SWITCH_CTRL_ADDR |=>
        ((reg_rdata ^ $past(reg_wdata, 2)) & 8'h0f) == 8'h00)
        else $error("throw bits not read back");
    chk_throw_follows_reg: assert property (reg_wr && reg_addr == SWITCH_CTRL_ADDR &&
        !mode_q ##1 !reg_wr [*2] |=> (({4'h0, throw_close} ^ $past(reg_wdata, 3)) & 8'h0f) == 8'h00)
        else $error("throw outputs not following register");
    chk_throw_follows_pins: assert property ((mode_q && $stable(parallel_throw_input)) [*6]
        |-> throw_close == parallel_throw_input)
        else $error("throw outputs not following pins");
    chk_irq_masked_low: assert property ((mask_q == 2'h0) [*3] |-> !irq)
        else $error("interrupt high while masked");
endmodule : throw_switch_ctrl_properties
`default_nettype wire

// file: bench/host_model.sv
/*
 host side of the register port: single-cycle strobes.
 assumes every task is entered just after a rising clk edge.
*/
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    // data stand only in the cycle after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
        @(posedge clk);
    endtask : rd
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
        @(posedge clk);
    endtask : wr_rd
endmodule : host_model
`default_nettype wire

// file: bench/throw_switch_ctrl_bench.sv
/*
 self-checking bench for the switch register block.
 assumes the host model on the register port and a 250 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module throw_switch_ctrl_bench;
    import throw_switch_pkg::*;
    localparam int CC = 4;
    logic       clk = 1'b0;
    // starts high so the first drive low is a real edge at time zero
    logic       resetn = 1'b1;
    logic [1:0] config_error = 2'h0;
    logic [3:0] pins = 4'h0;
    logic [7:0] addr, wdata, rdata;
    logic       wr, rd, irq;
    logic [3:0] throw_close;
    int         miscompares = 0;
    int         n_checks = 0;
    always #2 clk = ~clk;
    host_model host (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd));
    throw_switch_ctrl #(.CHECK_COUNT(CC)) uut (.clk(clk), .resetn(resetn), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .config_error(config_error), .parallel_throw_input(pins),
        .throw_close(throw_close), .irq(irq));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host.rd(a, v);
        check("read data", exp, v);
    endtask : rd_chk
    task automatic reset_dut(input logic [1:0] c);
        config_error <= c;
        resetn <= 1'b0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        repeat (CC + 12) @(posedge clk);
    endtask : reset_dut
    task automatic t_reset_values();
        rd_chk(SWITCH_CTRL_ADDR, SWITCH_CTRL_RESET);
        rd_chk(IRQ_STATUS_ADDR, 8'h00);
        rd_chk(IRQ_MASK_ADDR, IRQ_MASK_RESET);
        rd_chk(MODE_CTRL_ADDR, MODE_CTRL_RESET);
    endtask : t_reset_values
    task automatic t_throws();
        logic [7:0] v;
        // fault bits set on purpose; reserved bits kept zero as software must
        for (int i = 0; i < 4; i++) begin
            host.wr_rd(SWITCH_CTRL_ADDR, 8'hc0 | (8'h01 << i), v);
            check("readback", 8'h01 << i, v);
            repeat (3) @(posedge clk);
            check("throw_close", {4'h0, 4'h1 << i}, {4'h0, throw_close});
        end
    endtask : t_throws
    task automatic t_irq();
        host.wr(IRQ_MASK_ADDR, 8'h02);
        // irq lands on the edge after the mask write
        @(posedge clk);
        check("irq raised", 8'h01, {7'h0, irq});
        rd_chk(IRQ_STATUS_ADDR, 8'h02);
        repeat (2) @(posedge clk);
        check("irq cleared", 8'h00, {7'h0, irq});
        rd_chk(IRQ_STATUS_ADDR, 8'h00);
        host.wr(IRQ_MASK_ADDR, 8'h00);
    endtask : t_irq
    task automatic t_unmapped();
        host.wr(8'h30, 8'hff);
        rd_chk(8'h30, 8'h00);
        rd_chk(SWITCH_CTRL_ADDR, 8'h08);
    endtask : t_unmapped
    task automatic t_parallel();
        host.wr(MODE_CTRL_ADDR, 8'h01);
        pins <= 4'ha;
        repeat (8) @(posedge clk);
        check("pin throws", 8'h0a, {4'h0, throw_close});
        rd_chk(SWITCH_CTRL_ADDR, 8'h08);
        host.wr(MODE_CTRL_ADDR, 8'h00);
        repeat (6) @(posedge clk);
        check("reg throws", 8'h08, {4'h0, throw_close});
    endtask : t_parallel
    task automatic t_fault();
        for (int k = 1; k < 4; k++) begin
            reset_dut(2'(k));
            rd_chk(SWITCH_CTRL_ADDR, {2'(k), 6'h00});
            // the code is latched once, so later pin moves must not show
            config_error <= 2'(k) ^ 2'h3;
            repeat (10) @(posedge clk);
            rd_chk(SWITCH_CTRL_ADDR, {2'(k), 6'h00});
            host.wr(IRQ_MASK_ADDR, 8'h01);
            @(posedge clk);
            check("irq fault", 8'h01, {7'h0, irq});
            rd_chk(IRQ_STATUS_ADDR, 8'h01);
            repeat (2) @(posedge clk);
            check("irq fault cleared", 8'h00, {7'h0, irq});
        end
    endtask : t_fault
    initial begin
        reset_dut(2'h0);
        t_reset_values();
        t_throws();
        t_irq();
        t_unmapped();
        t_parallel();
        t_fault();
        print_verdict();
    end
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
endmodule : throw_switch_ctrl_bench
bind throw_switch_ctrl throw_switch_ctrl_properties #(.CHECK_COUNT(CHECK_COUNT)) chk (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .parallel_throw_input(parallel_throw_input), .throw_close(throw_close), .irq(irq));
`default_nettype wire
